// [ioc_pkg.sv]
/*
 * Constants, carrier structs and the state type of the isolated output
 * command controller.
 * Assumes the ASCII framing of the serial link and 13 output channels.
 */
package ioc_pkg;
    localparam logic [7:0] CH_CR = 8'h0d;
    localparam logic [7:0] CH_BANG = 8'h21;
    localparam logic [7:0] CH_QM = 8'h3f;
    localparam logic [7:0] CH_GT = 8'h3e;
    localparam logic [7:0] CH_TILDE = 8'h7e;
    localparam logic [7:0] CH_DOLLAR = 8'h24;
    localparam logic [7:0] CH_HASH = 8'h23;
    localparam logic [7:0] CH_AT = 8'h40;
    localparam logic [7:0] CH_PCT = 8'h25;
    localparam logic [7:0] CH_STAR = 8'h2a;
    localparam logic [7:0] CH_0 = 8'h30;
    localparam logic [7:0] CH_9 = 8'h39;
    localparam logic [7:0] CH_A = 8'h41;
    localparam logic [7:0] CH_F = 8'h46;
    localparam logic [7:0] CH_LA = 8'h61;
    localparam logic [7:0] CH_LF = 8'h66;
    localparam logic [7:0] HEX_UC = 8'h37;
    localparam logic [7:0] HEX_LC = 8'h57;
    localparam logic [7:0] CMD_STATUS = 8'h30;
    localparam logic [7:0] CMD_CLRTMO = 8'h31;
    localparam logic [7:0] CMD_RDCFG = 8'h32;
    localparam logic [7:0] CMD_RDSYNC = 8'h34;
    localparam logic [7:0] CMD_RDRST = 8'h35;
    localparam logic [7:0] CMD_RDIO = 8'h36;
    localparam logic [7:0] TYPE_DIO = 8'h40;
    localparam logic [7:0] BAUD_MIN = 8'h03;
    localparam logic [7:0] BAUD_MAX = 8'h0a;
    localparam logic [7:0] STAT_OK = 8'h00;
    localparam logic [7:0] STAT_TMO = 8'h04;
    localparam logic [7:0] PAD_B = 8'h00;
    localparam logic [7:0] BB_LO0 = 8'h00;
    localparam logic [7:0] BB_LOA = 8'h0a;
    localparam logic [7:0] BB_HI = 8'h0b;
    localparam logic [3:0] GRP_LO1 = 4'h1;
    localparam logic [3:0] GRP_LOA = 4'ha;
    localparam logic [3:0] GRP_HI = 4'hb;
    localparam logic [7:0] HI_MAX = 8'h1f;
    localparam logic [3:0] HI_CH_MAX = 4'h4;
    localparam logic [7:0] BIT_MAX = 8'h01;
    localparam logic [7:0] FMT_RSVD = 8'h3f;
    localparam int FMT_CHK = 6;
    localparam int FMT_EDGE = 7;
    localparam int BUF_DEPTH = 16;
    localparam int REP_DEPTH = 12;
    localparam int REP_W = 8 * REP_DEPTH;
    localparam logic [1:0] LOAD_CYC = 2'h3;
    localparam int CLK_MHZ = 40;
    localparam int MWD_TIME_US = 1000;
    localparam int MWD_CYC = MWD_TIME_US * CLK_MHZ;
    localparam int DO_W = 13;
    typedef struct packed {
        logic [7:0] id;
        logic [7:0] baud;
        logic [7:0] fmt;
    } ioc_cfg_t;
    typedef struct packed {
        ioc_cfg_t cfg;
        logic [DO_W-1:0] safe_val;
        logic [DO_W-1:0] pwron_val;
        logic tmo;
    } ioc_nv_t;
    localparam ioc_cfg_t FACTORY_CFG = '{id: 8'h01, baud: 8'h06, fmt: 8'h00};
    localparam ioc_cfg_t INIT_CFG = '{id: 8'h00, baud: 8'h06, fmt: 8'h00};
    typedef enum logic [1:0] {ST_LOAD, ST_RX, ST_EXEC, ST_TX} ioc_state_t;
endpackage

// [ioc_cmd_ctrl.sv]
/*
 * Command interpreter and output-state control of a 13-channel output
 * module: frame parser, replies, timeout and reset flags, self watchdog.
 * Assumes a receiver/transmitter on sys_clk handing over whole bytes and
 * an external non-volatile store that presents its content on nv_in.
 */
// How it works
// - reset with timeout clear loads power-on value
// - host watchdog expiry forces safe value, status 04
// - output commands refused with '!' during timeout
// - timeout flag persists until clear-timeout command
// - output command applies value, answers '>'
// - reset flag set on reset, read clears
// - own watchdog restarts module when execution stalls
// - init mode uses address 00, 9600, no checksum
// - baud or checksum change needs init mode
// - configuration frame layout and its replies
// - new configuration stored, used after next reset
// - baud codes 03 to 0A select rates
// - format bit 6 enables checksum, reserved zero
// - format bit 7 selects counter update edge
// - read data high group first, trailing 00
// - factory address 01, type 40, 9600
// - init-mode read configuration returns stored settings
// - broadcast sampling captures state, no reply
`timescale 1ns/1ps
module ioc_cmd_ctrl
    import ioc_pkg::*;
#(
    parameter int MWD_CYCLES = MWD_CYC
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic init_n_pin,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic tx_ready,
    input wire logic hwd_expire,
    input wire ioc_nv_t nv_in,
    input wire logic nv_blank,
    output logic [DO_W-1:0] do_out,
    output logic [7:0] tx_data,
    output logic tx_valid,
    output logic nv_cfg_wr,
    output ioc_cfg_t nv_cfg_out,
    output logic nv_tmo_out,
    output logic [7:0] baud_code_out,
    output logic chk_enabled,
    output logic cnt_edge_rise,
    output logic init_mode,
    output logic reset_flag
);
    function automatic logic [4:0] hn(input logic [7:0] c);
        if (c >= CH_0 && c <= CH_9) hn = {1'b1, 4'(c - CH_0)};
        else if (c >= CH_A && c <= CH_F) hn = {1'b1, 4'(c - HEX_UC)};
        else if (c >= CH_LA && c <= CH_LF) hn = {1'b1, 4'(c - HEX_LC)};
        else hn = 5'h00;
    endfunction

    function automatic logic [8:0] hx2(input logic [7:0] a, input logic [7:0] b);
        logic [4:0] x;
        logic [4:0] y;
        x = hn(a);
        y = hn(b);
        hx2 = {x[4] & y[4], x[3:0], y[3:0]};
    endfunction

    function automatic logic [7:0] th(input logic [3:0] n);
        th = (n < 4'ha) ? CH_0 + {4'h0, n} : HEX_UC + {4'h0, n};
    endfunction

    function automatic logic [15:0] hb(input logic [7:0] b);
        hb = {th(b[7:4]), th(b[3:0])};
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ioc_state_t st_reg, st_next;
    logic [1:0] ld_reg, ld_next;
    logic [2:0] pin_reg, pin_next;
    logic pin_flt_reg, pin_flt_next;
    logic init_reg, init_next;
    ioc_cfg_t act_reg, act_next;
    ioc_cfg_t nvcfg_reg, nvcfg_next;
    logic [DO_W-1:0] safe_reg, safe_next;
    logic [DO_W-1:0] pwron_reg, pwron_next;
    logic [DO_W-1:0] do_reg, do_next;
    logic tmo_reg, tmo_next;
    logic rst_flag_reg, rst_flag_next;
    logic [7:0] buf_reg [BUF_DEPTH];
    logic [7:0] buf_next [BUF_DEPTH];
    logic [4:0] cnt_reg, cnt_next;
    logic ovf_reg, ovf_next;
    logic [REP_W-1:0] rep_reg, rep_next;
    logic [3:0] rem_reg, rem_next;
    logic [7:0] tx_data_reg, tx_data_next;
    logic tx_valid_reg, tx_valid_next;
    logic nv_wr_reg, nv_wr_next;
    logic [DO_W-1:0] sync_val_reg, sync_val_next;
    logic sync_have_reg, sync_have_next;
    logic sync_new_reg, sync_new_next;
    logic [23:0] mwd_reg, mwd_next;
    logic mwd_fire;
    logic clr_tmo;

    // ------------------------------------------------------------
    // strap synchroniser
    // ------------------------------------------------------------
    // free running through reset: the strap must have settled by the load cycle
    always_comb begin
        pin_next = {pin_reg[1:0], init_n_pin};
        // a pin change counts only once the last two stages agree
        pin_flt_next = (pin_reg[2] == pin_reg[1]) ? pin_reg[2] : pin_flt_reg;
    end

    always_ff @(posedge sys_clk) begin
        pin_reg <= pin_next;
        pin_flt_reg <= pin_flt_next;
    end

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [REP_W-1:0] rv;
        logic [3:0] rl;
        logic [4:0] n;
        logic [7:0] sum;
        logic [8:0] ck, id, f1, f2, f3, f4;
        logic ok, addr_ok, good;
        logic [DO_W-1:0] newv;
        rv = '0;
        rl = 4'h0;
        n = cnt_reg;
        sum = 8'h00;
        ck = '0;
        id = '0;
        f1 = '0;
        f2 = '0;
        f3 = '0;
        f4 = '0;
        ok = 1'b0;
        addr_ok = 1'b0;
        good = 1'b0;
        newv = do_reg;
        clr_tmo = 1'b0;
        st_next = st_reg;
        ld_next = ld_reg;
        init_next = init_reg;
        act_next = act_reg;
        nvcfg_next = nvcfg_reg;
        safe_next = safe_reg;
        pwron_next = pwron_reg;
        do_next = do_reg;
        tmo_next = tmo_reg;
        rst_flag_next = rst_flag_reg;
        buf_next = buf_reg;
        cnt_next = cnt_reg;
        ovf_next = ovf_reg;
        rep_next = rep_reg;
        rem_next = rem_reg;
        tx_data_next = tx_data_reg;
        tx_valid_next = tx_valid_reg;
        nv_wr_next = 1'b0;
        sync_val_next = sync_val_reg;
        sync_have_next = sync_have_reg;
        sync_new_next = sync_new_reg;
        // kicked whenever the interpreter is back waiting for input
        mwd_next = (st_reg == ST_RX || st_reg == ST_LOAD) ? 24'h0 : mwd_reg + 24'h1;
        mwd_fire = (mwd_reg == 24'(MWD_CYCLES - 1));
        case (st_reg)
            ST_LOAD: begin
                ld_next = ld_reg + 2'h1;
                if (ld_reg == LOAD_CYC) begin
                    // the strap is only taken here, after the filter has settled
                    init_next = !pin_flt_reg;
                    nvcfg_next = nv_blank ? FACTORY_CFG : nv_in.cfg;
                    act_next = !pin_flt_reg ? INIT_CFG : nvcfg_next;
                    safe_next = nv_in.safe_val;
                    pwron_next = nv_in.pwron_val;
                    tmo_next = nv_in.tmo && !nv_blank;
                    do_next = tmo_next ? nv_in.safe_val : nv_in.pwron_val;
                    st_next = ST_RX;
                end
            end
            ST_RX: begin
                if (rx_valid) begin
                    if (rx_data == CH_CR) st_next = ST_EXEC;
                    else if (cnt_reg < 5'(BUF_DEPTH)) begin
                        buf_next[cnt_reg[3:0]] = rx_data;
                        cnt_next = cnt_reg + 5'h1;
                    end else ovf_next = 1'b1;
                end
            end
            ST_EXEC: begin
                cnt_next = 5'h0;
                ovf_next = 1'b0;
                ok = !ovf_reg;
                if (act_reg.fmt[FMT_CHK]) begin
                    n = cnt_reg - 5'h2;
                    ck = hx2(buf_reg[n[3:0]], buf_reg[4'(n + 5'h1)]);
                    for (int i = 0; i < BUF_DEPTH; i++) if (i < int'(n)) sum = sum + buf_reg[i];
                    ok = ok && cnt_reg >= 5'h2 && ck[8] && ck[7:0] == sum;
                end
                id = hx2(buf_reg[1], buf_reg[2]);
                addr_ok = ok && id[8] && id[7:0] == act_reg.id;
                f1 = hx2(buf_reg[3], buf_reg[4]);
                f2 = hx2(buf_reg[5], buf_reg[6]);
                f3 = hx2(buf_reg[7], buf_reg[8]);
                f4 = hx2(buf_reg[9], buf_reg[10]);
                if (addr_ok) begin
                    rv = REP_W'({CH_QM, hb(act_reg.id)});
                    rl = 4'h3;
                end
                case (buf_reg[0])
                    CH_TILDE: if (addr_ok && n == 5'h4) begin
                        if (buf_reg[3] == CMD_STATUS) begin
                            rv = REP_W'({CH_BANG, hb(act_reg.id), hb(tmo_reg ? STAT_TMO : STAT_OK)});
                            rl = 4'h5;
                        end else if (buf_reg[3] == CMD_CLRTMO) begin
                            clr_tmo = 1'b1;
                            rv = REP_W'({CH_BANG, hb(act_reg.id)});
                        end
                    end
                    CH_DOLLAR: if (addr_ok && n == 5'h4) begin
                        if (buf_reg[3] == CMD_RDCFG) begin
                            rv = REP_W'({CH_BANG, hb(act_reg.id), hb(TYPE_DIO), hb(nvcfg_reg.baud),
                                hb(nvcfg_reg.fmt)});
                            rl = 4'h9;
                        end else if (buf_reg[3] == CMD_RDSYNC && sync_have_reg) begin
                            rv = REP_W'({CH_BANG, CH_0 | {7'h00, sync_new_reg},
                                hb({3'h0, sync_val_reg[12:8]}), hb(sync_val_reg[7:0]), hb(PAD_B)});
                            rl = 4'h8;
                            sync_new_next = 1'b0;
                        end else if (buf_reg[3] == CMD_RDRST) begin
                            rv = REP_W'({CH_BANG, hb(act_reg.id), CH_0 | {7'h00, rst_flag_reg}});
                            rl = 4'h4;
                            rst_flag_next = 1'b0;
                        end else if (buf_reg[3] == CMD_RDIO) begin
                            rv = REP_W'({CH_BANG, hb({3'h0, do_reg[12:8]}), hb(do_reg[7:0]),
                                hb(PAD_B)});
                            rl = 4'h7;
                        end
                    end
                    CH_HASH: begin
                        if (ok && n == 5'h3 && buf_reg[1] == CH_STAR && buf_reg[2] == CH_STAR) begin
                            sync_val_next = do_reg;
                            sync_have_next = 1'b1;
                            sync_new_next = 1'b1;
                        end else if (addr_ok && n == 5'h7 && f1[8] && f2[8]) begin
                            if (f1[7:0] == BB_LO0 || f1[7:0] == BB_LOA) begin
                                newv[7:0] = f2[7:0];
                                good = 1'b1;
                            end else if (f1[7:0] == BB_HI && f2[7:0] <= HI_MAX) begin
                                newv[12:8] = f2[4:0];
                                good = 1'b1;
                            end else if ((f1[7:4] == GRP_LO1 || f1[7:4] == GRP_LOA) && !f1[3]
                                && f2[7:0] <= BIT_MAX) begin
                                newv[f1[2:0]] = f2[0];
                                good = 1'b1;
                            end else if (f1[7:4] == GRP_HI && f1[3:0] <= HI_CH_MAX
                                && f2[7:0] <= BIT_MAX) begin
                                newv[4'(f1[2:0]) + 4'h8] = f2[0];
                                good = 1'b1;
                            end
                        end
                    end
                    CH_AT: if (addr_ok && n == 5'h7 && f1[8] && f2[8] && f1[7:0] <= HI_MAX) begin
                        newv = {f1[4:0], f2[7:0]};
                        good = 1'b1;
                    end
                    CH_PCT: if (addr_ok && n == 5'hb && f1[8] && f2[8] && f3[8] && f4[8]
                        && f2[7:0] == TYPE_DIO && f3[7:0] >= BAUD_MIN && f3[7:0] <= BAUD_MAX
                        && (f4[7:0] & FMT_RSVD) == 8'h00
                        && (init_reg || (f3[7:0] == act_reg.baud
                        && f4[FMT_CHK] == act_reg.fmt[FMT_CHK]))) begin
                        nv_wr_next = 1'b1;
                        nvcfg_next = '{id: f1[7:0], baud: f3[7:0], fmt: f4[7:0]};
                        rv = REP_W'({CH_BANG, hb(f1[7:0])});
                    end
                    default: ;
                endcase
                if (good) begin
                    rv = REP_W'(tmo_reg ? CH_BANG : CH_GT);
                    rl = 4'h1;
                    if (!tmo_reg) do_next = newv;
                end
                if (rl != 4'h0) begin
                    if (act_reg.fmt[FMT_CHK]) begin
                        sum = 8'h00;
                        for (int i = 0; i < REP_DEPTH; i++) if (i < int'(rl)) sum = sum + rv[8*i +: 8];
                        rv = {rv[REP_W-17:0], hb(sum)};
                        rl = rl + 4'h2;
                    end
                    rv = {rv[REP_W-9:0], CH_CR};
                    rl = rl + 4'h1;
                    st_next = ST_TX;
                    tx_valid_next = 1'b1;
                    tx_data_next = rv[8*(int'(rl)-1) +: 8];
                end else st_next = ST_RX;
                rep_next = rv;
                rem_next = rl;
            end
            ST_TX: begin
                if (tx_ready) begin
                    if (rem_reg == 4'h1) begin
                        tx_valid_next = 1'b0;
                        st_next = ST_RX;
                    end else tx_data_next = rep_reg[8*(int'(rem_reg)-2) +: 8];
                    rem_next = rem_reg - 4'h1;
                end
            end
            default: st_next = ST_RX;
        endcase
        if (clr_tmo) tmo_next = 1'b0;
        // expiry after the clear so a coinciding event is kept
        if (hwd_expire) begin
            tmo_next = 1'b1;
            do_next = safe_next;
        end
        if (mwd_fire) begin
            // a stalled link partner also trips this: replies cannot hang forever
            st_next = ST_LOAD;
            ld_next = 2'h0;
            mwd_next = 24'h0;
            rst_flag_next = 1'b1;
            tx_valid_next = 1'b0;
            cnt_next = 5'h0;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= ST_LOAD;
            ld_reg <= 2'h0;
            init_reg <= 1'b0;
            act_reg <= FACTORY_CFG;
            nvcfg_reg <= FACTORY_CFG;
            safe_reg <= '0;
            pwron_reg <= '0;
            do_reg <= '0;
            tmo_reg <= 1'b0;
            rst_flag_reg <= 1'b1;
            for (int i = 0; i < BUF_DEPTH; i++) buf_reg[i] <= 8'h00;
            cnt_reg <= 5'h0;
            ovf_reg <= 1'b0;
            rep_reg <= '0;
            rem_reg <= 4'h0;
            tx_data_reg <= 8'h00;
            tx_valid_reg <= 1'b0;
            nv_wr_reg <= 1'b0;
            sync_val_reg <= '0;
            sync_have_reg <= 1'b0;
            sync_new_reg <= 1'b0;
            mwd_reg <= 24'h0;
        end else begin
            st_reg <= st_next;
            ld_reg <= ld_next;
            init_reg <= init_next;
            act_reg <= act_next;
            nvcfg_reg <= nvcfg_next;
            safe_reg <= safe_next;
            pwron_reg <= pwron_next;
            do_reg <= do_next;
            tmo_reg <= tmo_next;
            rst_flag_reg <= rst_flag_next;
            buf_reg <= buf_next;
            cnt_reg <= cnt_next;
            ovf_reg <= ovf_next;
            rep_reg <= rep_next;
            rem_reg <= rem_next;
            tx_data_reg <= tx_data_next;
            tx_valid_reg <= tx_valid_next;
            nv_wr_reg <= nv_wr_next;
            sync_val_reg <= sync_val_next;
            sync_have_reg <= sync_have_next;
            sync_new_reg <= sync_new_next;
            mwd_reg <= mwd_next;
        end
    end

    assign do_out = do_reg;
    assign tx_data = tx_data_reg;
    assign tx_valid = tx_valid_reg;
    assign nv_cfg_wr = nv_wr_reg;
    assign nv_cfg_out = nvcfg_reg;
    assign nv_tmo_out = tmo_reg;
    assign baud_code_out = act_reg.baud;
    assign chk_enabled = act_reg.fmt[FMT_CHK];
    assign cnt_edge_rise = act_reg.fmt[FMT_EDGE];
    assign init_mode = init_reg;
    assign reset_flag = rst_flag_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_hwd_forces_safe: assert property (hwd_expire && st_reg != ST_LOAD && !mwd_fire
        |=> tmo_reg && do_reg == safe_reg) else $error("timeout did not force safe value");
    a_tmo_holds_out: assert property (tmo_reg && st_reg != ST_LOAD |-> do_reg == safe_reg)
        else $error("outputs left safe value during timeout");
    a_tmo_sticky: assert property (tmo_reg && !clr_tmo && st_reg != ST_LOAD |=> tmo_reg)
        else $error("timeout flag dropped without clear");
    a_pwron_load: assert property (st_reg == ST_LOAD && ld_reg == LOAD_CYC ##1 !tmo_reg
        |-> do_reg == pwron_reg) else $error("power-on value not applied");
    a_mwd_reset_flag: assert property (mwd_fire |=> rst_flag_reg && st_reg == ST_LOAD)
        else $error("watchdog restart missing");
    a_mwd_bounded: assert property (mwd_reg < MWD_CYCLES)
        else $error("module watchdog overran");
    a_init_cfg: assert property (init_reg && st_reg != ST_LOAD |-> act_reg == INIT_CFG)
        else $error("init mode settings not in use");
    a_cfg_deferred: assert property (nv_wr_reg |-> $stable(act_reg))
        else $error("configuration applied before reset");
    a_reply_ends_cr: assert property (tx_valid_reg && tx_ready && rem_reg == 4'h1
        |-> tx_data_reg == CH_CR) else $error("reply not closed by carriage return");
endmodule // ioc_cmd_ctrl

// [ioc_host_model.sv]
/* Host side of the serial link at byte level.
   Assumes the controller takes one byte per cycle while receiving. */
`timescale 1ns/1ps
module ioc_host_model (
    input wire logic sys_clk,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic tx_ready
);
    bit slow = 1'b0;
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b0;
    end
    // frames go out whole, ended by cr
    task automatic send(input string s);
        foreach (s[i]) begin
            @(negedge sys_clk);
            rx_data = s[i];
            rx_valid = 1'b1;
        end
        @(negedge sys_clk);
        rx_valid = 1'b0;
        rx_data = ~rx_data;
    endtask
    // slow host accepts every other cycle; cr is taken but not kept
    task automatic get(output string r);
        r = "";
        for (int n = 0; n < 60; n++) begin
            @(negedge sys_clk);
            tx_ready = slow ? ~tx_ready : 1'b1;
            if (tx_ready && tx_valid) begin
                if (tx_data == 8'h0d) break;
                r = {r, string'(tx_data)};
            end
        end
        @(negedge sys_clk);
        tx_ready = 1'b0;
    endtask
endmodule // ioc_host_model

// [tb_top.sv]
/* Self-checking bench of the command controller with a host byte model.
   Assumes a 40 MHz clock and the module watchdog shortened to 64 cycles. */
`timescale 1ns/1ps
module tb_top;
    import ioc_pkg::*;
    localparam logic [DO_W-1:0] PWRON = 13'h0a5c;
    localparam logic [DO_W-1:0] SAFE = 13'h1e03;
    logic sys_clk = 0, sys_rst = 1, init_n_pin = 1, hwd_expire = 0, nv_blank = 0;
    logic [7:0] rx_data, tx_data, baud_code_out;
    logic rx_valid, tx_ready, tx_valid, nv_cfg_wr, nv_tmo_out, chk_enabled;
    logic cnt_edge_rise, init_mode, reset_flag;
    logic [DO_W-1:0] do_out;
    ioc_cfg_t nv_cfg_out;
    ioc_nv_t nv_in = '{cfg: FACTORY_CFG, safe_val: SAFE, pwron_val: PWRON, tmo: 1'b0};
    int n_fail = 0, checks_done = 0, n_wr = 0;
    always #12.5 sys_clk = ~sys_clk;
    always @(negedge sys_clk) if (nv_cfg_wr === 1'b1) n_wr++;
    ioc_cmd_ctrl #(.MWD_CYCLES(64)) ioc_cmd_ctrl_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .init_n_pin(init_n_pin), .rx_data(rx_data), .rx_valid(rx_valid),
        .tx_ready(tx_ready), .hwd_expire(hwd_expire), .nv_in(nv_in), .nv_blank(nv_blank),
        .do_out(do_out), .tx_data(tx_data), .tx_valid(tx_valid), .nv_cfg_wr(nv_cfg_wr),
        .nv_cfg_out(nv_cfg_out), .nv_tmo_out(nv_tmo_out), .baud_code_out(baud_code_out),
        .chk_enabled(chk_enabled), .cnt_edge_rise(cnt_edge_rise), .init_mode(init_mode),
        .reset_flag(reset_flag));
    ioc_host_model ioc_host_model_i (.sys_clk(sys_clk), .tx_data(tx_data),
        .tx_valid(tx_valid), .rx_data(rx_data), .rx_valid(rx_valid), .tx_ready(tx_ready));
    task automatic chk_v(string nm, logic [15:0] e, logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_s(string nm, string e, string g);
        checks_done++;
        if (g != e) begin
            n_fail++;
            $display("[FAIL] %s expected '%s' seen '%s'", nm, e, g);
        end
    endtask
    task automatic cmd(string c, string e);
        string r;
        ioc_host_model_i.send({c, "\r"});
        ioc_host_model_i.get(r);
        chk_s(c, e, r);
    endtask
    task automatic restart(bit init);
        @(negedge sys_clk);
        init_n_pin = ~init; // strap set while powered down
        sys_rst = 1'b1;
        repeat (8) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (6) @(negedge sys_clk);
    endtask
    task automatic conclude;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_power;
        nv_blank = 1'b1;
        nv_in.cfg.baud = 8'h0a;
        nv_in.tmo = 1'b1;
        restart(1'b0);
        nv_blank = 1'b0;
        nv_in.cfg = FACTORY_CFG;
        nv_in.tmo = 1'b0;
        chk_v("do_out", 16'(PWRON), 16'(do_out));
        chk_v("reset_flag", 16'h1, 16'(reset_flag));
        chk_v("baud", 16'h06, 16'(baud_code_out));
        chk_v("edge", 16'h0, 16'(cnt_edge_rise));
        cmd("$015", "!011");
        cmd("$015", "!010");
        cmd("$025", "");
        cmd("%0101400700", "?01");
        $display("t_power done");
    endtask
    task automatic t_out;
        ioc_host_model_i.slow = 1'b1;
        cmd("#010012", ">");
        cmd("#010B1F", ">");
        cmd("#011400", ">");
        chk_v("do_out", 16'h1f02, 16'(do_out));
        cmd("@01155A", ">");
        cmd("#**", "");
        cmd("$016", "!155A00");
        cmd("$014", "!1155A00");
        cmd("$014", "!0155A00");
        ioc_host_model_i.slow = 1'b0;
        $display("t_out done");
    endtask
    task automatic t_tmo;
        @(negedge sys_clk);
        hwd_expire = 1'b1;
        @(negedge sys_clk);
        hwd_expire = 1'b0;
        @(negedge sys_clk);
        chk_v("do_out", 16'(SAFE), 16'(do_out));
        chk_v("nv_tmo", 16'h1, 16'(nv_tmo_out));
        cmd("#010012", "!");
        chk_v("do_out", 16'(SAFE), 16'(do_out));
        cmd("~010", "!0104");
        nv_in.tmo = nv_tmo_out;
        restart(1'b0);
        chk_v("do_out", 16'(SAFE), 16'(do_out));
        cmd("~011", "!01");
        chk_v("nv_tmo", 16'h0, 16'(nv_tmo_out));
        cmd("#010012", ">");
        nv_in.tmo = nv_tmo_out;
        $display("t_tmo done");
    endtask
    task automatic t_wdog;
        cmd("$015", "!011");
        ioc_host_model_i.send("$016\r");
        repeat (80) @(negedge sys_clk);
        chk_v("reset_flag", 16'h1, 16'(reset_flag));
        chk_v("tx_valid", 16'h0, 16'(tx_valid));
        chk_v("do_out", 16'(PWRON), 16'(do_out));
        $display("t_wdog done");
    endtask
    task automatic t_init;
        nv_in.cfg.fmt = 8'h40;
        restart(1'b1);
        chk_v("init_mode", 16'h1, 16'(init_mode));
        chk_v("chk_en", 16'h0, 16'(chk_enabled));
        cmd("$002", "!00400640");
        cmd("%0005300600", "?00");
        cmd("%00054008c0", "!05");
        chk_v("cfg writes", 16'h1, 16'(n_wr));
        chk_v("baud", 16'h06, 16'(baud_code_out));
        nv_in.cfg = nv_cfg_out;
        restart(1'b0);
        chk_v("baud", 16'h08, 16'(baud_code_out));
        chk_v("chk_en", 16'h1, 16'(chk_enabled));
        chk_v("edge", 16'h1, 16'(cnt_edge_rise));
        cmd("$056BF", "!0A5C006A");
        cmd("$05600", "");
        $display("t_init done");
    endtask
    initial begin
        t_power;
        t_out;
        t_tmo;
        t_wdog;
        t_init;
        conclude;
    end
    initial begin
        #500000;
        n_fail++;
        conclude;
    end
endmodule // tb_top
